// ---- core/osd_fringe_border_smoothing.sv ----
// Operation
// - Fringe shadow below and right of dots
// - Fringe width full or half dot
// - Largest character fringe spills past cell
// - Spilled fringe shown; character dots win
// - Mode one: fringe on enabled lines
// - Mode zero: border on enabled lines
// - Border outlines all sides, half dot
// - Effect colour from control field bits
// - Spilled border shown; character dots win
// - Half vertical dot uses one field
// - Quarter-dot fill on corner-only contacts
// - Smoothing enabled per line by masks
// - Inter-character smoothing joins side neighbours
// - Control writes take effect next row, except display enable
// - Row counter readable in display control
//
// Added by the designer: the address map and register access over Avalon-MM.
module osd_fringe_border_smoothing #(
  parameter int ROW_COUNT = 12
) (
  input  wire  logic                     clk_i,
  input  wire  logic                     reset_i,
  input  wire  logic [4:0]               avs_address_i,
  input  wire  logic                     avs_read_i,
  input  wire  logic                     avs_write_i,
  input  wire  logic [31:0]              avs_writedata_i,
  output logic       [31:0]              avs_readdata_o,
  output logic                           avs_waitrequest_o,
  input  wire  osd_effect_pkg::sync_t    sync_i,
  input  wire  osd_effect_pkg::dot_in_t  dot_i,
  output osd_effect_pkg::dot_out_t       dot_o,
  output logic                           irq_o
);
  import osd_effect_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // Enable masks hold twelve line bits; the counter is four bits
  if (ROW_COUNT < 1 || ROW_COUNT > 12) begin : g_bad_rows
    $error("ROW_COUNT must lie between 1 and 12");
  end

  // Status and mask bits must fit the written byte
  if (EV_COUNT < 1 || EV_COUNT > 8) begin : g_bad_events
    $error("EV_COUNT must lie between 1 and 8");
  end

  // Row field must fit the low byte of the display word
  if (DC_ROW_LSB + 4 > 8) begin : g_bad_row_field
    $error("Row field must fit the low byte");
  end

  localparam logic [3:0] ROW_LAST = 4'(ROW_COUNT - 1);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    bus_state_t          bus;
    logic                waitreq;
    logic [31:0]         rdata;
    osd_regs_t           live;
    osd_regs_t           act;
    logic                disp_en;
    logic [3:0]          row;
    logic                row_seen;
    logic [EV_COUNT-1:0] irq_stat;
    logic [EV_COUNT-1:0] irq_mask;
    logic                irq;
    dot_out_t            dout;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ************************************************************
  // Dot effect helpers
  // ************************************************************
  logic [11:0] edge_en;
  logic [11:0] smooth_en;
  logic        line_edge;
  logic        line_smooth;
  logic        fringe_mode;
  logic        half_fringe;
  logic        inter_chr;
  logic [2:0]  effect_color;
  logic [7:0]  n;
  logic [7:0]  ok;
  logic        h;
  logic        f;
  logic        fringe_hit;
  logic        border_hit;
  logic        smooth_hit;
  // Half-dot position of the current dot
  logic        left_half;
  logic        even_field;
  // Per-term effect hits
  logic        fr_left;
  logic        fr_up;
  logic        fr_corner;
  logic        bd_left;
  logic        bd_right;
  logic        bd_up;
  logic        bd_down;
  logic        bd_up_left;
  logic        bd_up_right;
  logic        bd_down_left;
  logic        bd_down_right;
  logic        sm_up_left;
  logic        sm_up_right;
  logic        sm_down_left;
  logic        sm_down_right;
  // Effect choice after line gating
  logic        show_smooth;
  logic        show_fringe;
  logic        show_border;

  // Active copies only, so a mid-row write cannot tear a row
  always_comb begin
    edge_en      = {s_q.act.edge_effect_control_b[3:0],
                    s_q.act.edge_effect_line_enable_a};
    smooth_en    = {s_q.act.smoothing_line_enable_b[3:0],
                    s_q.act.smoothing_line_enable_a};
    line_edge    = edge_en[s_q.row];
    line_smooth  = smooth_en[s_q.row];
    fringe_mode  = s_q.act.edge_effect_control_b[EB_MODE_BIT];
    half_fringe  = s_q.act.space_color_options[SC_HALF_DOT_BIT];
    inter_chr    = s_q.act.space_color_options[SC_INTER_CHR_BIT];
    effect_color = s_q.act.edge_effect_control_b[EB_COLOR_LSB +: 3];
    n            = dot_i.nbr_lit;
    h            = dot_i.right_half;
    f            = dot_i.odd_field;
    left_half    = ~dot_i.right_half;
    even_field   = ~dot_i.odd_field;
  end

  // ************************************************************
  // Fringe
  // ************************************************************
  // Neighbours from any cell count, so spilled shadow is drawn
  always_comb begin
    if (half_fringe) begin
      // Half dot: left half when right of a lit dot, even field when below one
      fr_left   = n[NB_L] & left_half;
      fr_up     = n[NB_U] & even_field;
      fr_corner = n[NB_UL] & left_half & even_field;
    end else begin
      // Full dot: whole dot right of and below a lit dot
      fr_left   = n[NB_L];
      fr_up     = n[NB_U];
      fr_corner = n[NB_UL];
    end
    fringe_hit = fr_left | fr_up | fr_corner;
  end

  // ************************************************************
  // Border
  // ************************************************************
  // Border is always half a dot, on the side facing the lit dot
  always_comb begin
    // Sides: the half column or field that faces the lit dot
    bd_left       = n[NB_L] & left_half;
    bd_right      = n[NB_R] & h;
    bd_up         = n[NB_U] & even_field;
    bd_down       = n[NB_D] & f;
    // Corners: the quarter that faces a diagonal lit dot
    bd_up_left    = n[NB_UL] & left_half & even_field;
    bd_up_right   = n[NB_UR] & h & even_field;
    bd_down_left  = n[NB_DL] & left_half & f;
    bd_down_right = n[NB_DR] & h & f;
    border_hit    = bd_left | bd_right | bd_up | bd_down
                  | bd_up_left | bd_up_right | bd_down_left | bd_down_right;
  end

  // ************************************************************
  // Smoothing
  // ************************************************************
  // Corner fill needs both orthogonal neighbours in one character; with inter_chr set only the vertical one
  always_comb begin
    ok            = dot_i.nbr_same;
    ok[NB_L]      = dot_i.nbr_same[NB_L] | inter_chr;
    ok[NB_R]      = dot_i.nbr_same[NB_R] | inter_chr;
    // Quarter dot: one half column in one field
    sm_up_left    = n[NB_U] & ok[NB_U] & n[NB_L] & ok[NB_L] & left_half & even_field;
    sm_up_right   = n[NB_U] & ok[NB_U] & n[NB_R] & ok[NB_R] & h & even_field;
    sm_down_left  = n[NB_D] & ok[NB_D] & n[NB_L] & ok[NB_L] & left_half & f;
    sm_down_right = n[NB_D] & ok[NB_D] & n[NB_R] & ok[NB_R] & h & f;
    smooth_hit    = sm_up_left | sm_up_right | sm_down_left | sm_down_right;
  end

  // ************************************************************
  // Dot output selection
  // ************************************************************
  // Effects gated by their line enables; a clear line shows none
  always_comb begin
    show_smooth = line_smooth & smooth_hit;
    show_fringe = line_edge & fringe_mode & fringe_hit;
    show_border = line_edge & ~fringe_mode & border_hit;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  logic                bus_req;
  logic [EV_COUNT-1:0] events;
  logic [EV_COUNT-1:0] w1c;
  logic [7:0]          wbyte;
  logic [31:0]         rword;

  always_comb begin
    s_d     = s_q;
    bus_req = avs_read_i | avs_write_i;
    wbyte   = avs_writedata_i[7:0];
    events  = '0;
    w1c     = '0;
    rword   = WORD_ZERO;

    // Read mux, narrow registers in the low byte
    case (avs_address_i)
      ADDR_SPACE_COLOR: rword[7:0] = s_q.live.space_color_options;
      ADDR_EDGE_A:      rword[7:0] = s_q.live.edge_effect_line_enable_a;
      ADDR_EDGE_B:      rword[7:0] = s_q.live.edge_effect_control_b;
      ADDR_SMOOTH_A:    rword[7:0] = s_q.live.smoothing_line_enable_a;
      ADDR_SMOOTH_B:    rword[7:0] = s_q.live.smoothing_line_enable_b;
      ADDR_DISPLAY: begin
        rword[DC_ROW_LSB +: 4] = s_q.row;
        rword[DC_ENABLE_BIT]   = s_q.disp_en;
      end
      ADDR_IRQ_STATUS:  rword[EV_COUNT-1:0] = s_q.irq_stat;
      ADDR_IRQ_MASK:    rword[EV_COUNT-1:0] = s_q.irq_mask;
      default:          rword = WORD_ZERO;                  // Unmapped reads zero
    endcase

    // Two-cycle slave: waitrequest drops in the cycle after the request
    case (s_q.bus)
      BUS_IDLE: begin
        if (bus_req) begin
          s_d.bus     = BUS_ACK;
          s_d.waitreq = 1'b0;
          s_d.rdata  = rword;
        end
      end
      BUS_ACK: begin
        s_d.bus     = BUS_IDLE;
        s_d.waitreq = 1'b1;
        if (avs_write_i) begin
          case (avs_address_i)
            ADDR_SPACE_COLOR: s_d.live.space_color_options       = wbyte;
            ADDR_EDGE_A:      s_d.live.edge_effect_line_enable_a = wbyte;
            ADDR_EDGE_B:      s_d.live.edge_effect_control_b     = wbyte;
            ADDR_SMOOTH_A:    s_d.live.smoothing_line_enable_a   = wbyte;
            ADDR_SMOOTH_B:    s_d.live.smoothing_line_enable_b   = wbyte;
            // Output enable bypasses the row shadow on purpose
            ADDR_DISPLAY:     s_d.disp_en = wbyte[DC_ENABLE_BIT];
            ADDR_IRQ_STATUS:  w1c = wbyte[EV_COUNT-1:0];
            ADDR_IRQ_MASK:    s_d.irq_mask = wbyte[EV_COUNT-1:0];
            default:          ;                             // Unmapped writes ignored
          endcase
        end
      end
      default: begin
        s_d.bus     = BUS_IDLE;
        s_d.waitreq = 1'b1;
      end
    endcase

    // Row counter and shadow load at each row start
    if (sync_i.frame_start) begin
      s_d.row_seen = 1'b0;
      s_d.row      = ROW_ZERO;
      events[EV_FRAME] = 1'b1;
    end else if (sync_i.row_start) begin
      s_d.row_seen = 1'b1;
      if (!s_q.row_seen) begin
        s_d.row = ROW_ZERO;
      end else if (s_q.row != ROW_LAST) begin
        s_d.row = s_q.row + ROW_ONE;
      end
      // Writes made in row N become visible from row N+1
      s_d.act = s_d.live;
      events[EV_ROW] = 1'b1;
    end

    // Set wins over a simultaneous write-one clear
    s_d.irq_stat = (s_q.irq_stat & ~w1c) | events;
    s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);

    // Dot priority: character, smoothing, edge effect, background
    s_d.dout.valid = dot_i.valid;
    if (!s_q.disp_en) begin
      s_d.dout.kind = DOT_BACKGROUND;
      s_d.dout.rgb  = COLOR_BLACK;
    end else if (dot_i.lit) begin
      s_d.dout.kind = DOT_CHARACTER;
      s_d.dout.rgb  = dot_i.char_color;
    end else if (show_smooth) begin
      s_d.dout.kind = DOT_SMOOTH;
      s_d.dout.rgb  = dot_i.char_color;
    end else if (show_fringe) begin
      s_d.dout.kind = DOT_EDGE;
      s_d.dout.rgb  = effect_color;
    end else if (show_border) begin
      s_d.dout.kind = DOT_EDGE;
      s_d.dout.rgb  = effect_color;
    end else begin
      s_d.dout.kind = DOT_BACKGROUND;
      s_d.dout.rgb  = dot_i.back_color;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q.bus      <= BUS_IDLE;
      s_q.waitreq  <= 1'b1;
      s_q.rdata    <= WORD_ZERO;
      s_q.live     <= {5{REG_RESET}};
      s_q.act      <= {5{REG_RESET}};
      s_q.disp_en  <= 1'b0;
      s_q.row      <= ROW_ZERO;
      s_q.row_seen <= 1'b0;
      s_q.irq_stat <= '0;
      s_q.irq_mask <= '0;
      s_q.irq      <= 1'b0;
      s_q.dout     <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Outputs straight from the state flops; no gate after them
  assign avs_waitrequest_o = s_q.waitreq;
  assign avs_readdata_o    = s_q.rdata;
  assign dot_o             = s_q.dout;
  assign irq_o             = s_q.irq;

endmodule // osd_fringe_border_smoothing

// ---- inc/osd_effect_pkg.sv ----
package osd_effect_pkg;

  // ************************************************************
  // Register map (byte addresses, one 32-bit word each)
  // ************************************************************
  localparam logic [4:0] ADDR_SPACE_COLOR = 5'h00;
  localparam logic [4:0] ADDR_EDGE_A      = 5'h04;
  localparam logic [4:0] ADDR_EDGE_B      = 5'h08;
  localparam logic [4:0] ADDR_SMOOTH_A    = 5'h0C;
  localparam logic [4:0] ADDR_SMOOTH_B    = 5'h10;
  localparam logic [4:0] ADDR_DISPLAY     = 5'h14;
  localparam logic [4:0] ADDR_IRQ_STATUS  = 5'h18;
  localparam logic [4:0] ADDR_IRQ_MASK    = 5'h1C;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int          SC_HALF_DOT_BIT  = 3;
  localparam int          SC_INTER_CHR_BIT = 4;
  localparam int          EB_MODE_BIT      = 7;
  localparam int          EB_COLOR_LSB     = 4;
  localparam int          DC_ENABLE_BIT    = 0;
  localparam int          DC_ROW_LSB       = 4;
  localparam logic [7:0]  REG_RESET        = 8'h00;
  localparam logic [7:0]  UPPER_EN_MASK    = 8'h0F;
  localparam logic [3:0]  ROW_ZERO         = 4'h0;
  localparam logic [3:0]  ROW_ONE          = 4'h1;
  localparam logic [31:0] WORD_ZERO        = 32'h0000_0000;
  localparam logic [2:0]  COLOR_BLACK      = 3'h0;

  // Interrupt events
  localparam int          EV_ROW   = 0;
  localparam int          EV_FRAME = 1;
  localparam int          EV_COUNT = 2;

  // Neighbour positions in the 3x3 dot window
  localparam int NB_UL = 0;
  localparam int NB_U  = 1;
  localparam int NB_UR = 2;
  localparam int NB_L  = 3;
  localparam int NB_R  = 4;
  localparam int NB_DL = 5;
  localparam int NB_D  = 6;
  localparam int NB_DR = 7;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

  typedef enum logic [1:0] {
    DOT_BACKGROUND = 2'h0,
    DOT_CHARACTER  = 2'h1,
    DOT_EDGE       = 2'h2,
    DOT_SMOOTH     = 2'h3
  } dot_kind_t;

  typedef struct packed {
    logic       frame_start;
    logic       row_start;
  } sync_t;

  typedef struct packed {
    logic       valid;
    logic       lit;
    logic [7:0] nbr_lit;
    logic [7:0] nbr_same;
    logic       right_half;
    logic       odd_field;
    logic [2:0] char_color;
    logic [2:0] back_color;
  } dot_in_t;

  typedef struct packed {
    logic       valid;
    dot_kind_t  kind;
    logic [2:0] rgb;
  } dot_out_t;

  typedef struct packed {
    logic [7:0] space_color_options;
    logic [7:0] edge_effect_line_enable_a;
    logic [7:0] edge_effect_control_b;
    logic [7:0] smoothing_line_enable_a;
    logic [7:0] smoothing_line_enable_b;
  } osd_regs_t;

endpackage

// ---- verification/osd_fringe_border_smoothing_monitor.sv ----
module osd_fringe_border_smoothing_monitor (
  input wire logic                     clk_i,
  input wire logic                     reset_i,
  input wire logic [4:0]               avs_address_i,
  input wire logic                     avs_read_i,
  input wire logic                     avs_write_i,
  input wire logic [31:0]              avs_writedata_i,
  input wire logic                     avs_waitrequest_o,
  input wire osd_effect_pkg::sync_t    sync_i,
  input wire osd_effect_pkg::dot_in_t  dot_i,
  input wire osd_effect_pkg::dot_out_t dot_o,
  input wire logic                     irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import osd_effect_pkg::*;
  // ****************************************
  // Bus and dot stream checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_wait_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("No answer");
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("Answer too long");
  a_wait_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("Answer without request");
  a_dot_latency: assert property (dot_i.valid |=> dot_o.valid)
    else $error("Dot lost");
  a_char_color: assert property (
    dot_o.kind == DOT_CHARACTER && dot_o.rgb != COLOR_BLACK |-> dot_o.rgb == $past(dot_i.char_color))
    else $error("Bad character colour");
  a_edge_cause: assert property (
    dot_o.kind == DOT_EDGE |-> $past(!dot_i.lit && dot_i.nbr_lit != 8'h00)) else $error("Stray edge");
  a_smooth_cause: assert property (
    dot_o.kind == DOT_SMOOTH |-> $past(!dot_i.lit && $countones(dot_i.nbr_lit) > 1))
    else $error("Stray smoothing");
  a_bg_color: assert property (
    dot_o.valid && dot_o.kind == DOT_BACKGROUND && dot_o.rgb != COLOR_BLACK
    |-> dot_o.rgb == $past(dot_i.back_color)) else $error("Bad background colour");
  a_irq_clear: assert property (
    avs_write_i && !avs_waitrequest_o && avs_address_i == ADDR_IRQ_STATUS
    && avs_writedata_i[1:0] == 2'b11 && sync_i == 2'b00 ##1 sync_i == 2'b00 |-> ##[0:1] !irq_o)
    else $error("Interrupt not cleared");
endmodule // osd_fringe_border_smoothing_monitor

bind osd_fringe_border_smoothing osd_fringe_border_smoothing_monitor monitor_inst (
  .clk_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_waitrequest_o, .sync_i, .dot_i, .dot_o, .irq_o);

// ---- verification/osd_fringe_border_smoothing_tb.sv ----
module osd_fringe_border_smoothing_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import osd_effect_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  sync_t       sync_i = '0;
  dot_in_t     dot_i = '0;
  dot_out_t    dot_o;
  dot_out_t    seen;
  logic        irq_o;
  logic [31:0] rd;
  int          failures = 0;
  int          n_tests = 0;
  // ****************************************
  // Block, display and clock
  // ****************************************
  osd_fringe_border_smoothing osd_fringe_border_smoothing_inst (
    .clk_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .sync_i, .dot_i, .dot_o, .irq_o);
  tv_display_model tv_display_model_inst (.clk_i, .dot_i(dot_o), .seen_o(seen));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (failures == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h00_0000, d};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask
  task automatic pulse(input sync_t s);
    @(posedge clk_i);
    sync_i <= s;
    @(posedge clk_i);
    sync_i <= '0;
  endtask
  // One dot in, judged once the display has shown it; pos is right half, odd field
  task automatic dot(input logic lit, input logic [7:0] nl, input logic [7:0] ns,
                     input logic [1:0] pos, input dot_kind_t k, input logic [2:0] c);
    @(posedge clk_i);
    dot_i <= '{1'b1, lit, nl, ns, pos[1], pos[0], 3'h2, 3'h1};
    @(posedge clk_i);
    dot_i.valid <= 1'b0;
    @(posedge clk_i);
    #1 chk(32'(seen), 32'({1'b1, k, c}));
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [4:0] a [5] = '{ADDR_SPACE_COLOR, ADDR_EDGE_A, ADDR_EDGE_B, ADDR_SMOOTH_A, ADDR_SMOOTH_B};
    foreach (a[i]) begin
      rdchk(a[i], 8'h00);
      wr(a[i], 8'h5A + 8'(i));
      rdchk(a[i], 8'h5A + 8'(i));
    end
    wr(ADDR_DISPLAY, 8'h01);
    rdchk(ADDR_DISPLAY, 8'h01);
  endtask
  // Rows 0-2 carry edges, rows 4-5 smoothing; changes land at the next row
  task automatic t_fringe;
    wr(ADDR_EDGE_A, 8'h07);
    wr(ADDR_EDGE_B, 8'hD0);
    wr(ADDR_SPACE_COLOR, 8'h00);
    wr(ADDR_SMOOTH_A, 8'h30);
    wr(ADDR_SMOOTH_B, 8'h00);
    pulse(2'b10);
    pulse(2'b01);
    dot(1'b1, 8'h08, 8'h00, 2'b00, DOT_CHARACTER, 3'h2);
    dot(1'b0, 8'h08, 8'h00, 2'b10, DOT_EDGE, 3'h5);
    dot(1'b0, 8'h02, 8'h00, 2'b01, DOT_EDGE, 3'h5);
    dot(1'b0, 8'h10, 8'h00, 2'b00, DOT_BACKGROUND, 3'h1);
    wr(ADDR_EDGE_B, 8'h30);
    dot(1'b0, 8'h10, 8'h00, 2'b10, DOT_BACKGROUND, 3'h1);
    pulse(2'b01);
    dot(1'b0, 8'h10, 8'h00, 2'b10, DOT_EDGE, 3'h3);
    dot(1'b0, 8'h10, 8'h00, 2'b00, DOT_BACKGROUND, 3'h1);
    dot(1'b0, 8'h40, 8'h00, 2'b01, DOT_EDGE, 3'h3);
    dot(1'b0, 8'h40, 8'h00, 2'b00, DOT_BACKGROUND, 3'h1);
    wr(ADDR_SPACE_COLOR, 8'h08); // half-dot test dots stand apart
    wr(ADDR_EDGE_B, 8'hD0);
    pulse(2'b01);
    dot(1'b0, 8'h08, 8'h00, 2'b00, DOT_EDGE, 3'h5);
    dot(1'b0, 8'h08, 8'h00, 2'b10, DOT_BACKGROUND, 3'h1);
    dot(1'b0, 8'h02, 8'h00, 2'b01, DOT_BACKGROUND, 3'h1);
    pulse(2'b01);
    dot(1'b0, 8'h08, 8'h00, 2'b00, DOT_BACKGROUND, 3'h1);
  endtask
  task automatic t_smooth;
    pulse(2'b01);
    dot(1'b0, 8'h12, 8'h12, 2'b10, DOT_SMOOTH, 3'h2);
    dot(1'b0, 8'h12, 8'h12, 2'b00, DOT_BACKGROUND, 3'h1);
    dot(1'b0, 8'h12, 8'h02, 2'b10, DOT_BACKGROUND, 3'h1);
    wr(ADDR_SPACE_COLOR, 8'h10);
    pulse(2'b01);
    dot(1'b0, 8'h12, 8'h02, 2'b10, DOT_SMOOTH, 3'h2);
  endtask
  // Row starts pend in status; only the row event is let through
  task automatic t_irq;
    rdchk(ADDR_DISPLAY, 8'h51);
    wr(ADDR_IRQ_MASK, 8'h01);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 32'h0000_0001);
    wr(ADDR_IRQ_STATUS, 8'h03);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 32'h0000_0000);
    pulse(2'b10);
    pulse(2'b01);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 32'h0000_0001);
    rdchk(ADDR_IRQ_STATUS, 8'h03);
    rdchk(ADDR_DISPLAY, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 32'h0000_0000);
  endtask
  // Main sequence and watchdog share one ending
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_fringe();
    t_smooth();
    t_irq();
    print_verdict();
  end
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
endmodule // osd_fringe_border_smoothing_tb

// ---- verification/tv_display_model.sv ----
module tv_display_model (
  input  wire logic                     clk_i,
  input  wire osd_effect_pkg::dot_out_t dot_i,
  output osd_effect_pkg::dot_out_t      seen_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import osd_effect_pkg::*;
  // Screen keeps the last shown dot; blank clocks leave it alone
  always_ff @(posedge clk_i) begin
    if (dot_i.valid) begin
      seen_o <= dot_i;
    end
  end
endmodule // tv_display_model
